// ---- tdl_pkg.sv ----
// constants, register map and field layout for the transmit diagnostic block
//
// Summary of operation
// - forced all-ones overrides system transmit data
// - digital loopback keeps original data despite all-ones
// - diagnostic patterns replace system transmit data
// - digital loopback path intact during diagnostics
// - self-sourced patterns always use single rail
// - auto all-ones only on channels losing signal
// - generate 2^20-1 and 2^15-1 random sequences
// - segment code is sign plus 6-bit magnitude
// - five preset short-haul shape codes 08h-0ch
// - pulse is eight segments, presets fixed
// - arbitrary mode takes segments from registers
// - sign bit one means negative excursion
// - all-ones code gives full-rail magnitude
// - arbitrary segments reset to zero level
// - failure flag after 128 idle clocks
// - flag change pulls interrupt low if enabled
// - status read releases interrupt, clears latch
// - tri-state bit floats line driver
// - analog loopback feeds transmit back to receive
// - remote loopback retransmits recovered line data
// - digital loopback sends system data to receive
// - dual loopback is remote plus digital
package tdl_pkg;

  // register port geometry
  localparam int AW = 8;
  localparam int DW = 16;

  // register offsets (byte addresses, one word each)
  localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFS_SHAPE    = 8'h04;
  localparam logic [AW-1:0] OFS_SEG_BASE = 8'h08;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h28;

  // control register fields
  localparam int CTRL_W        = 11;
  localparam int CB_FORCE      = 0;   // force_all_ones
  localparam int CB_AUTO       = 1;   // auto_all_ones_on_loss
  localparam int CB_PAT_EN     = 2;   // random pattern enable
  localparam int CB_PAT_SHORT  = 3;   // 0: 2^20-1, 1: 2^15-1
  localparam int CB_TRI        = 4;   // tx_tristate_select
  localparam int CB_LB_ANALOG  = 5;   // local analog loopback
  localparam int CB_LB_REMOTE  = 6;   // remote loopback
  localparam int CB_LB_DIGITAL = 7;   // digital loopback (dual = 6+7)
  localparam int CB_IRQ_EN     = 8;   // driver failure interrupt enable
  localparam int CB_SINGLE     = 9;   // single rail system data
  localparam int CB_TX_RISING  = 10;  // sample system data on rising edge
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

  // shape register fields
  localparam int SHAPE_W  = 6;
  localparam int SB_ARB   = 5;        // arbitrary pulse mode
  localparam logic [SHAPE_W-1:0] SHAPE_RST = 6'h08;

  // pulse segments
  localparam int SEG_NUM   = 8;
  localparam int SEG_W     = 7;
  localparam int SEG_SIGN  = 6;
  localparam logic [SEG_W-1:0] SEG_RST = 7'h00;
  localparam logic [SEG_NUM*SEG_W-1:0] SEGS_RST = 56'h0;
  localparam logic [1:0] SEG_CYCLES = 2'd2; // clocks per segment

  // preset short-haul codes
  localparam logic [4:0] PRESET_LO = 5'h08;
  localparam logic [4:0] PRESET_HI = 5'h0c;
  // preset segment bases, segment 0 in the low bits
  localparam logic [SEG_NUM*SEG_W-1:0] PRESET_BASE =
    {7'h42, 7'h46, 7'h04, 7'h20, 7'h26, 7'h28, 7'h2c, 7'h22};

  // status register fields
  localparam int ST_FLAG   = 0;       // driver_failure_flag, live
  localparam int ST_CHANGE = 1;       // latched flag change, clear on read
  localparam int ST_LOS    = 2;       // receive_signal_loss, live

  // driver monitor
  localparam logic [7:0] IDLE_LIMIT = 8'd128;

  // pattern generators
  localparam logic [19:0] LFSR_SEED     = 20'h00001;
  localparam logic [3:0]  QRSS_ZERO_MAX = 4'd14;

endpackage

// ---- tdl_pulse_if.sv ----
// pulse request and dac result between channel logic and shaper
`timescale 1ns/100ps
`default_nettype none
interface tdl_pulse_if;
  logic        start;     // one-cycle pulse request
  logic        negative;  // polarity of requested pulse
  logic        arb_en;    // arbitrary segment mode
  logic [4:0]  code;      // pulse_shape_code
  logic [55:0] segs;      // eight arbitrary segment codes
  logic [6:0]  dac;       // registered dac code
  logic        busy;      // pulse in progress
  modport ctrl   (output start, negative, arb_en, code, segs,
                  input dac, busy);
  modport shaper (input start, negative, arb_en, code, segs,
                  output dac, busy);
endinterface
`default_nettype wire

// ---- tdl_prbs_gen.sv ----
// random test pattern generator, long and short sequences
`timescale 1ns/100ps
`default_nettype none
module tdl_prbs_gen (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic step_i,     // advance one bit
  input  wire logic short_i,    // select 2^15-1 sequence
  output logic      bit_o       // current pattern bit
);
  import tdl_pkg::*;

  typedef struct packed {
    logic [19:0] lfsr;   // shift state
    logic [3:0]  zrun;   // consecutive zeros sent
    logic        bit_q;  // registered output bit
  } tdl_prbs_st_t;

  tdl_prbs_st_t st, next_st;
  logic         fb;

  // next state: shift on step, cap zero runs on the long sequence
  always_comb begin
    next_st = st;
    fb = short_i ? (st.lfsr[14] ^ st.lfsr[13])
                 : (st.lfsr[19] ^ st.lfsr[16]);
    if (step_i) begin
      next_st.lfsr = {st.lfsr[18:0], fb};
      next_st.bit_q = fb;
      if (!short_i && !fb && st.zrun == QRSS_ZERO_MAX) begin
        next_st.bit_q = 1'b1;
      end
      next_st.zrun = next_st.bit_q ? 4'd0 : st.zrun + 4'd1;
      // a mode switch can leave the short window empty; reseed it
      if (short_i && next_st.lfsr[14:0] == 15'h0) begin
        next_st.lfsr = LFSR_SEED;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '{lfsr: LFSR_SEED, zrun: 4'd0, bit_q: 1'b0};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign bit_o = st.bit_q;

  property p_zero_run;
    @(posedge clk_i) disable iff (srst_i)
      st.zrun <= QRSS_ZERO_MAX;
  endproperty
  a_zero_run: assert property (p_zero_run)
    else $error("zero run exceeds limit");

  property p_lfsr_live;
    @(posedge clk_i) disable iff (srst_i)
      (ce_i && step_i && !short_i) |=> st.lfsr != 20'h0;
  endproperty
  a_lfsr_live: assert property (p_lfsr_live)
    else $error("long lfsr locked at zero");
endmodule
`default_nettype wire

// ---- tdl_pulse_shaper.sv ----
// eight-segment pulse shaper driving the line dac code
`timescale 1ns/100ps
`default_nettype none
module tdl_pulse_shaper (
  input  wire logic   clk_i,
  input  wire logic   srst_i,
  input  wire logic   ce_i,
  tdl_pulse_if.shaper pif
);
  import tdl_pkg::*;

  typedef struct packed {
    logic       busy;     // pulse running
    logic [2:0] idx;      // current segment
    logic [1:0] cnt;      // clocks spent in segment
    logic       neg;      // pulse polarity
    logic [6:0] dac;      // registered dac code
    logic [4:0] age;      // busy clocks since the last request, saturating
  } tdl_shp_st_t;

  tdl_shp_st_t st, next_st;

  // segment code for one index: preset table or arbitrary register
  function automatic logic [6:0] seg_code(input logic arb,
      input logic [4:0] code, input logic [55:0] segs,
      input logic [2:0] idx, input logic neg);
    logic [6:0] v;
    logic [5:0] mag;
    v = 7'h00;
    mag = 6'h00;
    if (arb) begin
      v = segs[idx*SEG_W +: SEG_W];
    end else if (code >= PRESET_LO && code <= PRESET_HI) begin
      v = PRESET_BASE[idx*SEG_W +: SEG_W];
      // longer cable ranges lift the main lobe a little
      if (!v[SEG_SIGN]) begin
        mag = v[5:0] + {1'b0, code - PRESET_LO};
        v = {1'b0, mag};
      end
    end
    // a negative pulse mirrors each segment about zero
    if (neg && v[5:0] != 6'h0) begin
      v[SEG_SIGN] = ~v[SEG_SIGN];
    end
    return v;
  endfunction

  // step through eight segments, restart on a new request
  always_comb begin
    next_st = st;
    if (pif.start) begin
      next_st.busy = 1'b1;
      next_st.idx  = 3'd0;
      next_st.cnt  = 2'd0;
      next_st.neg  = pif.negative;
    end else if (st.busy) begin
      if (st.cnt == SEG_CYCLES - 2'd1) begin
        next_st.cnt = 2'd0;
        next_st.idx = st.idx + 3'd1;
        if (st.idx == 3'(SEG_NUM - 1)) begin
          next_st.busy = 1'b0;
        end
      end else begin
        next_st.cnt = st.cnt + 2'd1;
      end
    end
    if (next_st.busy) begin
      next_st.dac = seg_code(pif.arb_en, pif.code, pif.segs,
                             next_st.idx, next_st.neg);
    end else begin
      next_st.dac = 7'h00; // zero level between pulses
    end
    // pulse age for the length check; held at its top, never wraps
    if (pif.start) begin
      next_st.age = 5'h00;
    end else if (st.busy && st.age != 5'h1f) begin
      next_st.age = st.age + 5'h01;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign pif.dac  = st.dac;
  assign pif.busy = st.busy;

  property p_arb_zero;
    @(posedge clk_i) disable iff (srst_i)
      (ce_i && pif.arb_en && pif.segs == SEGS_RST) |=> st.dac == 7'h00;
  endproperty
  a_arb_zero: assert property (p_arb_zero)
    else $error("zero segments gave nonzero dac");

  property p_pulse_len;
    @(posedge clk_i) disable iff (srst_i || !ce_i)
      $fell(st.busy) |-> st.age == 5'(SEG_NUM * SEG_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse not sixteen clocks long");
endmodule
`default_nettype wire

// ---- tdl_tx_diag.sv ----
// per-channel transmit source select, loopbacks, driver monitor, registers
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tdl_tx_diag (
  input  wire logic                 CLK_I,
  input  wire logic                 SRST_I,
  input  wire logic                 CE_I,
  input  wire logic [tdl_pkg::AW-1:0] ADDR_I,
  input  wire logic [tdl_pkg::DW-1:0] WDATA_I,
  input  wire logic                 WE_I,
  input  wire logic                 RE_I,
  output logic      [tdl_pkg::DW-1:0] RDATA_O,
  input  wire logic                 TX_CLK_I,
  input  wire logic                 TX_POS_I,
  input  wire logic                 TX_NEG_I,
  input  wire logic                 RX_CLK_I,
  input  wire logic                 RX_POS_I,
  input  wire logic                 RX_NEG_I,
  input  wire logic                 RX_LOS_I,
  output logic      [6:0]           LINE_DAC_O,
  output logic                      LINE_OE_N_O,
  output logic                      RX_CLK_O,
  output logic                      RX_POS_O,
  output logic                      RX_NEG_O,
  output logic                      DRV_FAIL_O,
  output logic                      IRQ_N_O
);
  import tdl_pkg::*;

  typedef struct packed {
    logic [2:0]          sclk_sy;  // system clock synchroniser + history
    logic [1:0]          spos_sy;  // system positive data synchroniser
    logic [1:0]          sneg_sy;  // system negative data synchroniser
    logic [2:0]          rclk_sy;  // recovered clock synchroniser + history
    logic [1:0]          lpos_sy;  // recovered positive data
    logic [1:0]          lneg_sy;  // recovered negative data
    logic [1:0]          los_sy;   // receive_signal_loss
    logic [CTRL_W-1:0]   ctrl;     // control register
    logic [SHAPE_W-1:0]  shape;    // shape register
    logic [55:0]         segs;     // arbitrary segment codes
    logic [7:0]          idle_cnt; // bit periods without a pulse
    logic                flag;     // driver_failure_flag
    logic                change;   // latched flag change
    logic                irq_n;    // interrupt, active low
    logic                ami_neg;  // next ami mark is negative
    logic                start;    // pulse request to shaper
    logic                start_neg;// its polarity
    logic                oe_n;     // line driver enable, active low
    logic                lb_p;     // last sent positive mark
    logic                lb_n;     // last sent negative mark
    logic [DW-1:0]       rdata;    // read data, one cycle
    logic                rx_clk;   // receive clock to system
    logic                rx_pos;   // rx_pos_data_out
    logic                rx_neg;   // rx_neg_data_out
  } tdl_main_st_t;

  tdl_main_st_t st, next_st;

  tdl_pulse_if pif ();

  // pattern generator wiring
  logic pat_bit;
  logic pat_step;

  // decoded strobes and modes
  logic tx_edge;
  logic rx_edge;
  logic strobe;
  logic lb_remote;
  logic lb_digital;
  logic lb_analog;
  logic all_ones;
  logic use_ami;
  logic ami_bit;
  logic mark_p;
  logic mark_n;
  logic send;
  logic seg_hit_w;
  logic seg_hit_r;
  logic [2:0] seg_w;
  logic [2:0] seg_r;
  logic rd_status;
  logic flag_ev;

  // segment register decode, shared by the write and read paths
  function automatic logic seg_decode(input logic [AW-1:0] a,
                                      output logic [2:0] idx);
    logic [AW-1:0] d;
    d = a - OFS_SEG_BASE;
    idx = d[4:2];
    return a >= OFS_SEG_BASE && d < 8'(SEG_NUM * 4) && d[1:0] == 2'b00;
  endfunction

  tdl_prbs_gen u_prbs (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .ce_i    (CE_I),
    .step_i  (pat_step),
    .short_i (st.ctrl[CB_PAT_SHORT]),
    .bit_o   (pat_bit)
  );

  tdl_pulse_shaper u_shaper (
    .clk_i  (CLK_I),
    .srst_i (SRST_I),
    .ce_i   (CE_I),
    .pif    (pif.shaper)
  );

  // request side of the shaper comes straight from registers
  assign pif.start    = st.start;
  assign pif.negative = st.start_neg;
  assign pif.arb_en   = st.shape[SB_ARB];
  assign pif.code     = st.shape[4:0];
  assign pif.segs     = st.segs;

  // next-state logic for the whole channel
  always_comb begin
    next_st = st;
    // synchronisers: the first stage feeds only the second
    next_st.sclk_sy = {st.sclk_sy[1:0], TX_CLK_I};
    next_st.spos_sy = {st.spos_sy[0], TX_POS_I};
    next_st.sneg_sy = {st.sneg_sy[0], TX_NEG_I};
    next_st.rclk_sy = {st.rclk_sy[1:0], RX_CLK_I};
    next_st.lpos_sy = {st.lpos_sy[0], RX_POS_I};
    next_st.lneg_sy = {st.lneg_sy[0], RX_NEG_I};
    next_st.los_sy  = {st.los_sy[0], RX_LOS_I};

    // bit strobes: system clock on the chosen edge, recovered on rising
    tx_edge = st.ctrl[CB_TX_RISING]
            ? ( st.sclk_sy[1] && !st.sclk_sy[2])
            : (!st.sclk_sy[1] &&  st.sclk_sy[2]);
    rx_edge = st.rclk_sy[1] && !st.rclk_sy[2];

    lb_remote  = st.ctrl[CB_LB_REMOTE];
    lb_digital = st.ctrl[CB_LB_DIGITAL];
    lb_analog  = st.ctrl[CB_LB_ANALOG];
    all_ones   = st.ctrl[CB_FORCE]
               || (st.ctrl[CB_AUTO] && st.los_sy[1]);

    // remote loopback clocks the line from the recovered clock
    strobe = lb_remote ? rx_edge : tx_edge;

    // transmit source in priority order
    use_ami = 1'b1;
    ami_bit = 1'b0;
    mark_p  = 1'b0;
    mark_n  = 1'b0;
    if (lb_remote) begin
      // recovered bipolar marks, system inputs ignored
      use_ami = 1'b0;
      mark_p  = st.lpos_sy[1];
      mark_n  = st.lneg_sy[1];
    end else if (all_ones) begin
      ami_bit = 1'b1;
    end else if (st.ctrl[CB_PAT_EN]) begin
      ami_bit = pat_bit;
    end else if (st.ctrl[CB_SINGLE]) begin
      ami_bit = st.spos_sy[1];
    end else begin
      use_ami = 1'b0;
      mark_p  = st.spos_sy[1];
      mark_n  = st.sneg_sy[1];
    end
    if (use_ami) begin
      mark_p = ami_bit && !st.ami_neg;
      mark_n = ami_bit &&  st.ami_neg;
    end

    // pattern advances once per system bit while it is the source
    pat_step = tx_edge && st.ctrl[CB_PAT_EN] && !lb_remote && !all_ones;

    // a floating driver sends nothing; both marks at once is no pulse
    send = strobe && (mark_p ^ mark_n) && !st.ctrl[CB_TRI];
    next_st.start     = send;
    next_st.start_neg = mark_n;
    next_st.oe_n      = st.ctrl[CB_TRI];
    if (strobe && use_ami && ami_bit) begin
      next_st.ami_neg = !st.ami_neg;
    end
    if (strobe) begin
      next_st.lb_p = send && mark_p;
      next_st.lb_n = send && mark_n;
    end

    // driver monitor counts line bit periods with no pulse
    if (strobe) begin
      if (send) begin
        next_st.idle_cnt = 8'd0;
        next_st.flag     = 1'b0;
      end else if (st.idle_cnt == IDLE_LIMIT) begin
        next_st.flag     = 1'b1;
      end else begin
        next_st.idle_cnt = st.idle_cnt + 8'd1;
      end
    end
    flag_ev   = (next_st.flag != st.flag) && st.ctrl[CB_IRQ_EN];
    rd_status = RE_I && ADDR_I == OFS_STATUS;
    // a new change in the reading cycle stays latched
    next_st.change = flag_ev || (st.change && !rd_status);
    next_st.irq_n  = !next_st.change;

    // receive side toward the system
    if (lb_digital) begin
      // original system data, untouched by any transmit override
      next_st.rx_clk = st.sclk_sy[1];
      next_st.rx_pos = st.spos_sy[1];
      next_st.rx_neg = st.sneg_sy[1];
    end else if (lb_analog) begin
      // line receive marks ignored, transmit fed back; remote mode keeps the recovered clock
      next_st.rx_clk = lb_remote ? st.rclk_sy[1] : st.sclk_sy[1];
      next_st.rx_pos = st.lb_p;
      next_st.rx_neg = st.lb_n;
    end else begin
      next_st.rx_clk = st.rclk_sy[1];
      next_st.rx_pos = st.lpos_sy[1];
      next_st.rx_neg = st.lneg_sy[1];
    end

    // register writes
    seg_hit_w = seg_decode(ADDR_I, seg_w);
    if (WE_I) begin
      if (ADDR_I == OFS_CTRL) begin
        next_st.ctrl = WDATA_I[CTRL_W-1:0];
      end else if (ADDR_I == OFS_SHAPE) begin
        next_st.shape = WDATA_I[SHAPE_W-1:0];
      end else if (seg_hit_w) begin
        next_st.segs[seg_w*SEG_W +: SEG_W] = WDATA_I[SEG_W-1:0];
      end
    end

    // register reads: data only in the cycle after the strobe
    seg_hit_r = seg_decode(ADDR_I, seg_r);
    next_st.rdata = '0;
    if (RE_I) begin
      if (ADDR_I == OFS_CTRL) begin
        next_st.rdata = DW'(st.ctrl);
      end else if (ADDR_I == OFS_SHAPE) begin
        next_st.rdata = DW'(st.shape);
      end else if (seg_hit_r) begin
        next_st.rdata = DW'(st.segs[seg_r*SEG_W +: SEG_W]);
      end else if (rd_status) begin
        next_st.rdata = DW'({st.los_sy[1], st.change, st.flag});
      end
    end
  end

  // state register; clock enable freezes everything
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st       <= '0;
      st.ctrl  <= CTRL_RST;
      st.shape <= SHAPE_RST;
      st.segs  <= SEGS_RST;
      st.irq_n <= 1'b1;
    end else if (CE_I) begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign RDATA_O     = st.rdata;
  assign LINE_DAC_O  = pif.dac;
  assign LINE_OE_N_O = st.oe_n;
  assign RX_CLK_O    = st.rx_clk;
  assign RX_POS_O    = st.rx_pos;
  assign RX_NEG_O    = st.rx_neg;
  assign DRV_FAIL_O  = st.flag;
  assign IRQ_N_O     = st.irq_n;

  property p_force_ones;
    @(posedge CLK_I) disable iff (SRST_I)
      (CE_I && tx_edge && st.ctrl[CB_FORCE] && !lb_remote
       && !st.ctrl[CB_TRI]) |=> st.start;
  endproperty
  a_force_ones: assert property (p_force_ones)
    else $error("forced all-ones missed a mark");

  property p_digital_loop;
    @(posedge CLK_I) disable iff (SRST_I)
      (CE_I && lb_digital) |=> RX_POS_O == $past(st.spos_sy[1]);
  endproperty
  a_digital_loop: assert property (p_digital_loop)
    else $error("digital loopback lost system data");

  property p_tristate;
    @(posedge CLK_I) disable iff (SRST_I)
      (CE_I && st.ctrl[CB_TRI]) |=> LINE_OE_N_O && !st.start;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("driver not floated");

  property p_flag_rise;
    @(posedge CLK_I) disable iff (SRST_I)
      $rose(st.flag) |-> $past(st.idle_cnt) == IDLE_LIMIT;
  endproperty
  a_flag_rise: assert property (p_flag_rise)
    else $error("failure flag at wrong idle count");

  property p_irq_on_change;
    @(posedge CLK_I) disable iff (SRST_I)
      (CE_I && st.ctrl[CB_IRQ_EN] && next_st.flag != st.flag)
      |=> !IRQ_N_O;
  endproperty
  a_irq_on_change: assert property (p_irq_on_change)
    else $error("interrupt missed flag change");

  property p_read_release;
    @(posedge CLK_I) disable iff (SRST_I)
      (CE_I && RE_I && ADDR_I == OFS_STATUS && !flag_ev)
      |=> IRQ_N_O && !st.change;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("status read did not release interrupt");
endmodule
`default_nettype wire

// ---- tdl_framer_model.sv ----
// framer model: system transmit clock and marks, line receive marks
`timescale 1ns/100ps
`default_nettype none
module tdl_framer_model (
  input  wire logic tx_mark_i,  // next system bit
  input  wire logic rx_mark_i,  // next line bit
  output logic      clk_o,      // link clock, free running
  output logic      pos_o,      // system positive rail
  output logic      neg_o,      // system negative rail
  output logic      rx_pos_o,   // recovered positive mark
  output logic      rx_neg_o    // recovered negative mark
);
  logic tpol;  // ami polarity of system marks
  logic rpol;  // ami polarity of line marks
  initial begin
    {clk_o, pos_o, neg_o, rx_pos_o, rx_neg_o, tpol, rpol} = 7'h00;
  end
  // line rate clock runs free, 160 ns period
  always #80 clk_o = ~clk_o;
  // data moves on the rising edge, half a period clear of a falling sample
  always @(posedge clk_o) begin
    pos_o <= tx_mark_i & ~tpol;
    neg_o <= tx_mark_i & tpol;
    tpol  <= tpol ^ tx_mark_i;
  end
  // line marks move on the falling edge, away from the recovery edge
  always @(negedge clk_o) begin
    rx_pos_o <= rx_mark_i & ~rpol;
    rx_neg_o <= rx_mark_i & rpol;
    rpol     <= rpol ^ rx_mark_i;
  end
endmodule
`default_nettype wire

// ---- tdl_tx_diag_test.sv ----
// self-checking bench for the transmit diagnostic block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tdl_tx_diag_test;
  import tdl_pkg::*;
  logic          clk = 1'h0;          // 200 MHz bench clock
  logic          srst = 1'h1;         // held for eight cycles
  logic          we = 1'h0;           // write strobe
  logic          re = 1'h0;           // read strobe
  logic [AW-1:0] addr = 8'h00;        // register address
  logic [DW-1:0] wdata = 16'h0000;    // write data
  logic [DW-1:0] rdata;               // read data
  logic          tx_mark = 1'h0;      // system bit to framer
  logic          rx_mark = 1'h0;      // line bit to framer
  logic          los = 1'h0;          // receive loss of signal
  logic          lclk, spos, sneg, lpos, lneg;
  logic [6:0]    dac;                 // line dac code
  logic [6:0]    last = 7'h00;        // dac one cycle back
  logic          oe_n, rclk_o, rxp_o, rxn_o, fail, irq_n;
  int            err_count = 0;
  int            checks = 0;
  int            np = 0;              // pulse starts in window
  int            rxh = 0;             // cycles with receive mark high
  int            rxn = 0;             // cycles with negative mark high
  int            rch = 0;             // cycles with receive clock high
  logic [31:0]   seed = 32'd25943;    // xorshift state
  always #2.5 clk = ~clk;
  tdl_framer_model u_far (.tx_mark_i(tx_mark), .rx_mark_i(rx_mark),
    .clk_o(lclk), .pos_o(spos), .neg_o(sneg), .rx_pos_o(lpos),
    .rx_neg_o(lneg));
  tdl_tx_diag u_dut (.CLK_I(clk), .SRST_I(srst), .CE_I(1'h1),
    .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we), .RE_I(re), .RDATA_O(rdata),
    .TX_CLK_I(lclk), .TX_POS_I(spos), .TX_NEG_I(sneg), .RX_CLK_I(lclk),
    .RX_POS_I(lpos), .RX_NEG_I(lneg), .RX_LOS_I(los), .LINE_DAC_O(dac),
    .LINE_OE_N_O(oe_n), .RX_CLK_O(rclk_o), .RX_POS_O(rxp_o),
    .RX_NEG_O(rxn_o), .DRV_FAIL_O(fail), .IRQ_N_O(irq_n));
  // counts pulse starts and receive marks once outputs have settled
  always @(posedge clk) begin
    #1;
    if (dac !== 7'h00 && last === 7'h00) np++;
    if (rxp_o === 1'h1) rxh++;
    if (rxn_o === 1'h1) rxn++;
    if (rclk_o === 1'h1) rch++;
    last = dac;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // expected segment code, sign turned for a negative mark
  function automatic logic [6:0] seg_exp(input logic [6:0] s, input logic n);
    return s ^ {n, 6'h00};
  endfunction
  task automatic wrap_up;
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    we <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'h0;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    re <= 1'h1;
    addr <= a;
    @(posedge clk);
    re <= 1'h0;
    #1 d = rdata;
  endtask
  // settle past synchroniser and pulse lag, then count for n cycles
  task automatic win(input int n);
    repeat (40) @(posedge clk);
    np = 0;
    rxh = 0;
    rxn = 0;
    rch = 0;
    repeat (n) @(posedge clk);
  endtask
  // bounded wait for a pulse start; running out ends the run
  task automatic wait_pulse;
    logic p;
    p = 1'h1;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      #1;
      if (dac !== 7'h00 && !p) return;
      p = (dac !== 7'h00);
    end
    err_count++;
    wrap_up;
  endtask
  initial begin
    logic [DW-1:0] d;
    logic [6:0]    sg [8];
    logic          ng;
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    rd(OFS_CTRL, d);
    `CHK("ctrl", 16'h0000, d)
    rd(OFS_SHAPE, d);
    `CHK("shape", 16'h0008, d)
    rd(OFS_SEG_BASE, d);
    `CHK("seg0", 16'h0000, d)
    rd(8'h30, d);
    `CHK("unmapped", 16'h0000, d)
    wr(OFS_CTRL, 16'h0100);
    for (int k = 0; k < 6000 && fail !== 1'h1; k++) @(posedge clk);
    `CHK("fail", 1'h1, fail)
    if (fail !== 1'h1) wrap_up;
    repeat (2) @(posedge clk);
    `CHK("irq", 1'h0, irq_n)
    rd(OFS_STATUS, d);
    `CHK("status", 16'h0003, d)
    `CHK("irq", 1'h1, irq_n)
    wr(OFS_CTRL, 16'h0101);
    win(512);
    `CHK("ones", 1'h1, np >= 15)
    `CHK("fail", 1'h0, fail)
    `CHK("irq", 1'h0, irq_n)
    rd(OFS_STATUS, d);
    `CHK("status", 16'h0002, d)
    for (int c = 8; c <= 12; c++) begin
      wr(OFS_SHAPE, 16'(c));
      win(256);
      `CHK("preset", 1'h1, np >= 7)
    end
    wr(OFS_CTRL, 16'h0011);
    win(256);
    `CHK("tri", 0, np)
    `CHK("oe", 1'h1, oe_n)
    wr(OFS_CTRL, 16'h0081);
    win(512);
    `CHK("ones", 1'h1, np >= 15)
    `CHK("oe", 1'h0, oe_n)
    `CHK("rxmarks", 0, rxh + rxn)
    tx_mark <= 1'h1;
    wr(OFS_CTRL, 16'h0080);
    win(512);
    `CHK("digital", 1'h1, rxh > 0 && np >= 15)
    `CHK("rxneg", 1'h1, rxn > 0)
    `CHK("rxclk", 1'h1, rch > 0 && rch < 512)
    tx_mark <= 1'h0;
    rx_mark <= 1'h1;
    wr(OFS_CTRL, 16'h0020);
    win(512);
    `CHK("analog", 0, rxh)
    wr(OFS_CTRL, 16'h0021);
    win(512);
    `CHK("analog", 1'h1, rxh > 0 && np >= 15)
    wr(OFS_CTRL, 16'h0041);
    win(512);
    `CHK("remote", 1'h1, np >= 15)
    rx_mark <= 1'h0;
    win(512);
    `CHK("remote", 0, np)
    los <= 1'h1;
    wr(OFS_CTRL, 16'h0002);
    win(512);
    `CHK("auto", 1'h1, np >= 15)
    rd(OFS_STATUS, d);
    `CHK("status", 16'h0004, d)
    @(posedge clk);
    los <= 1'h0;
    win(512);
    `CHK("auto", 0, np)
    tx_mark <= 1'h1;
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL, m ? 16'h000c : 16'h0004);
      win(2048);
      `CHK("pattern", 1'h1, np > 0 && np < 60)
    end
    tx_mark <= 1'h0;
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_SHAPE, 16'h0028);
    win(256);
    `CHK("arb", 0, np)
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      sg[i] = (i == 7) ? 7'h7f : (seed[6:0] | 7'h01);
      wr(OFS_SEG_BASE + 8'(4 * i), {9'h000, sg[i]});
    end
    wait_pulse;
    ng = (dac !== sg[0]);
    for (int i = 0; i < 8; i++) begin
      `CHK("segment", seg_exp(sg[i], ng), dac)
      repeat (2) @(posedge clk);
      #1;
    end
    wrap_up;
  end
endmodule
`default_nettype wire
